// >>> src/global_clock_led_config.sv
// Global clock, RMII edge and LED configuration register bank with strap capture.
`timescale 1ns/1ps

module global_clock_led_config (
	input  wire logic                                    clk,
	input  wire logic                                    arst_n,
	input  wire global_clock_led_pkg::reg_req_t          req,
	output      global_clock_led_pkg::reg_rsp_t          rsp,
	input  wire logic                                    led_mode_strap_pin,
	input  wire logic                                    clock_mode_strap_pin,
	input  wire global_clock_led_pkg::port_status_t [1:0] port_status,
	output      logic [1:0]                              port_led_second,
	output      logic [1:0]                              port_led_first,
	output      logic                                    port_three_reduced_mii_negedge,
	output      logic                                    port_four_reduced_mii_negedge,
	output      logic                                    phy_power_save,
	output      logic                                    read_sample_fast_edge,
	output      global_clock_led_pkg::mgmt_clk_t         mgmt_clk_sel,
	output      logic                                    clock_mode_status,
	output      logic                                    pll_source_crystal,
	output      logic                                    reference_clock_output_pin_oe,
	output      logic                                    core_clock_external
);

	global_clock_led_pkg::state_t s_q;
	global_clock_led_pkg::state_t s_d;

	// Builds the read value of one register from the held configuration.
	function automatic logic [global_clock_led_pkg::DATA_W-1:0] read_value(
		input logic [global_clock_led_pkg::ADDR_W-1:0] addr,
		input global_clock_led_pkg::cfg_t               cfg
	);
		logic [global_clock_led_pkg::DATA_W-1:0] v;
		v = '0;
		case (addr)
			global_clock_led_pkg::ADDR_FACTORY_TEST_A: begin
				v = global_clock_led_pkg::FACTORY_TEST_A_RST;
			end
			global_clock_led_pkg::ADDR_RMII_EDGE_LED: begin
				v[global_clock_led_pkg::BIT_P3_EDGE]   = cfg.p3_negedge;
				v[global_clock_led_pkg::BIT_P4_EDGE]   = cfg.p4_negedge;
				v[global_clock_led_pkg::BIT_PHY_SAVE]  = cfg.phy_power_save;
				v[global_clock_led_pkg::BIT_LED_MODE]  = cfg.led_mode;
				v[global_clock_led_pkg::BIT_READ_EDGE] = cfg.read_edge_fast;
			end
			global_clock_led_pkg::ADDR_CLOCK_MODE_SEL: begin
				v[global_clock_led_pkg::BIT_CLK_MODE] = cfg.clock_mode;
				v[global_clock_led_pkg::CLK_SEL_LSB +: 2] = cfg.mgmt_clk;
				v[global_clock_led_pkg::BIT_RSVD_ONE] = global_clock_led_pkg::RSVD_ONE_VAL;
			end
			default: begin
				v = '0;
			end
		endcase
		return v;
	endfunction : read_value

	// Next-state logic: strap capture, register access and LED drive.
	always_comb begin
		logic taken;
		taken = (s_q.st == global_clock_led_pkg::ST_RUN);
		s_d = s_q;
		// Two-stage synchronisers for the strap pins.
		s_d.led_sync = {s_q.led_sync[0], led_mode_strap_pin};
		s_d.clk_sync = {s_q.clk_sync[0], clock_mode_strap_pin};
		s_d.rsp.valid = 1'b0;
		case (s_q.st)
			global_clock_led_pkg::ST_SETTLE: begin
				if (s_q.settle_cnt == global_clock_led_pkg::STRAP_SETTLE - 2'h1) begin
					s_d.st = global_clock_led_pkg::ST_CAPTURE;
				end else begin
					s_d.settle_cnt = s_q.settle_cnt + 2'h1;
				end
			end
			global_clock_led_pkg::ST_CAPTURE: begin
				s_d.cfg.led_mode   = s_q.led_sync[1];
				s_d.cfg.clock_mode = s_q.clk_sync[1];
				s_d.st = global_clock_led_pkg::ST_RUN;
			end
			global_clock_led_pkg::ST_RUN: begin
				s_d.st = global_clock_led_pkg::ST_RUN;
			end
			default: begin
				s_d.st = global_clock_led_pkg::ST_SETTLE;
			end
		endcase
		// Register writes; reserved and read-only bits keep their values.
		if (taken && req.wr) begin
			if (req.addr == global_clock_led_pkg::ADDR_RMII_EDGE_LED) begin
				s_d.cfg.p3_negedge = req.wdata[global_clock_led_pkg::BIT_P3_EDGE];
				s_d.cfg.p4_negedge = req.wdata[global_clock_led_pkg::BIT_P4_EDGE];
				s_d.cfg.phy_power_save = req.wdata[global_clock_led_pkg::BIT_PHY_SAVE];
				s_d.cfg.led_mode = req.wdata[global_clock_led_pkg::BIT_LED_MODE];
				s_d.cfg.read_edge_fast = req.wdata[global_clock_led_pkg::BIT_READ_EDGE];
			end
			// The clock mode status bit is never written here.
			if (req.addr == global_clock_led_pkg::ADDR_CLOCK_MODE_SEL) begin
				if (global_clock_led_pkg::mgmt_clk_t'(req.wdata[global_clock_led_pkg::CLK_SEL_LSB +: 2])
					!= global_clock_led_pkg::MGMT_CLK_RSVD) begin
					s_d.cfg.mgmt_clk = global_clock_led_pkg::mgmt_clk_t'(
						req.wdata[global_clock_led_pkg::CLK_SEL_LSB +: 2]);
				end
			end
		end
		// Register reads answer one cycle later.
		if (taken && req.rd) begin
			s_d.rsp.valid = 1'b1;
			s_d.rsp.data  = read_value(req.addr, s_q.cfg);
		end
		// LED pattern per port in the selected mode.
		for (int i = 0; i < global_clock_led_pkg::NUM_LED_PORTS; i++) begin
			if (!s_q.cfg.led_mode) begin
				s_d.led_second[i] = port_status[i].link & ~port_status[i].activity;
				s_d.led_first[i]  = port_status[i].link & port_status[i].speed_100;
			end else begin
				s_d.led_second[i] = port_status[i].link & port_status[i].speed_100
					& ~port_status[i].activity;
				s_d.led_first[i]  = port_status[i].link & port_status[i].full_duplex;
			end
		end
	end

	// State register; only constants are loaded under reset.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '{
				st:         global_clock_led_pkg::ST_SETTLE,
				settle_cnt: 2'h0,
				led_sync:   2'h0,
				clk_sync:   2'h0,
				cfg:        '{
					p3_negedge:     1'h0,
					p4_negedge:     1'h0,
					phy_power_save: 1'h0,
					led_mode:       global_clock_led_pkg::LED_MODE_DEFAULT,
					read_edge_fast: 1'h0,
					clock_mode:     global_clock_led_pkg::CLK_MODE_DEFAULT,
					mgmt_clk:       global_clock_led_pkg::MGMT_CLK_RST
				},
				rsp:        '{valid: 1'h0, data: 8'h00},
				led_second: 2'h0,
				led_first:  2'h0
			};
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state register.
	assign rsp                            = s_q.rsp;
	assign port_led_second                = s_q.led_second;
	assign port_led_first                 = s_q.led_first;
	assign port_three_reduced_mii_negedge = s_q.cfg.p3_negedge;
	assign port_four_reduced_mii_negedge  = s_q.cfg.p4_negedge;
	assign phy_power_save                 = s_q.cfg.phy_power_save;
	assign read_sample_fast_edge          = s_q.cfg.read_edge_fast;
	assign mgmt_clk_sel                   = s_q.cfg.mgmt_clk;
	assign clock_mode_status              = s_q.cfg.clock_mode;

	// Clock source steering follows the strapped clock mode.
	assign pll_source_crystal             = s_q.cfg.clock_mode;
	assign reference_clock_output_pin_oe  = s_q.cfg.clock_mode;
	assign core_clock_external            = ~s_q.cfg.clock_mode;

	// Checks on the register bank behaviour.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	// Edge selects follow a write to their register in the next cycle.
	port_three_edge_a: assert property (
		(s_q.st == global_clock_led_pkg::ST_RUN && req.wr
			&& req.addr == global_clock_led_pkg::ADDR_RMII_EDGE_LED)
		|=> port_three_reduced_mii_negedge == $past(req.wdata[global_clock_led_pkg::BIT_P3_EDGE]))
		else $error("Port three edge select did not follow the write.");

	port_four_edge_a: assert property (
		(s_q.st == global_clock_led_pkg::ST_RUN && req.wr
			&& req.addr == global_clock_led_pkg::ADDR_RMII_EDGE_LED)
		|=> port_four_reduced_mii_negedge == $past(req.wdata[global_clock_led_pkg::BIT_P4_EDGE]))
		else $error("Port four edge select did not follow the write.");

	// Straps are loaded in the capture state only.
	led_strap_a: assert property (
		s_q.st == global_clock_led_pkg::ST_CAPTURE |=> s_q.cfg.led_mode == $past(s_q.led_sync[1]))
		else $error("LED mode was not taken from the strap.");

	read_edge_a: assert property (
		!(s_q.st == global_clock_led_pkg::ST_RUN && req.wr
			&& req.addr == global_clock_led_pkg::ADDR_RMII_EDGE_LED)
		&& s_q.st == global_clock_led_pkg::ST_RUN |=> $stable(read_sample_fast_edge))
		else $error("Read sampling edge changed without a write.");

	// Clock steering must agree with the strapped mode at all times.
	clock_out_a: assert property (
		clock_mode_status |-> pll_source_crystal && reference_clock_output_pin_oe
			&& !core_clock_external)
		else $error("Clock mode does not drive the reference clock out.");

	external_clock_a: assert property (
		!clock_mode_status |-> core_clock_external && !pll_source_crystal
			&& !reference_clock_output_pin_oe)
		else $error("Normal mode does not use the external reference.");

	mode_readonly_a: assert property (
		s_q.st == global_clock_led_pkg::ST_RUN |=> $stable(clock_mode_status))
		else $error("Clock mode status changed after strap capture.");

	mode_strap_a: assert property (
		$rose(s_q.st == global_clock_led_pkg::ST_RUN) |-> clock_mode_status == $past(s_q.clk_sync[1]))
		else $error("Clock mode was not taken from the strap.");

	// The management clock field takes legal values and refuses the reserved one.
	clock_select_a: assert property (
		(s_q.st == global_clock_led_pkg::ST_RUN && req.wr
			&& req.addr == global_clock_led_pkg::ADDR_CLOCK_MODE_SEL
			&& req.wdata[global_clock_led_pkg::CLK_SEL_LSB +: 2] == global_clock_led_pkg::MGMT_CLK_41M)
		|=> mgmt_clk_sel == global_clock_led_pkg::MGMT_CLK_41M)
		else $error("Management clock select did not take value 00.");

	clock_reserved_a: assert property (
		(req.wr && req.wdata[global_clock_led_pkg::CLK_SEL_LSB +: 2]
			== global_clock_led_pkg::MGMT_CLK_RSVD)
		|=> mgmt_clk_sel != global_clock_led_pkg::MGMT_CLK_RSVD && $stable(mgmt_clk_sel))
		else $error("Reserved management clock value was stored.");

	factory_read_a: assert property (
		(s_q.st == global_clock_led_pkg::ST_RUN && req.rd
			&& req.addr == global_clock_led_pkg::ADDR_FACTORY_TEST_A)
		|=> rsp.valid && rsp.data == global_clock_led_pkg::FACTORY_TEST_A_RST)
		else $error("Factory test register read a wrong value.");

	// Every read taken in the run state is answered in the next cycle, and nothing else raises the answer.
	read_answer_a: assert property (
		(s_q.st == global_clock_led_pkg::ST_RUN && req.rd) |=> rsp.valid)
		else $error("Read was not answered in the next cycle.");

	no_stray_answer_a: assert property (
		!(s_q.st == global_clock_led_pkg::ST_RUN && req.rd) |=> !rsp.valid)
		else $error("Read answer appeared without a taken read.");

	unmapped_read_a: assert property (
		(s_q.st == global_clock_led_pkg::ST_RUN && req.rd
			&& req.addr != global_clock_led_pkg::ADDR_FACTORY_TEST_A
			&& req.addr != global_clock_led_pkg::ADDR_RMII_EDGE_LED
			&& req.addr != global_clock_led_pkg::ADDR_CLOCK_MODE_SEL)
		|=> rsp.data == '0)
		else $error("An unmapped offset read back nonzero.");

	// Nothing written before strap capture ends can reach the edge selects.
	early_drop_a: assert property (
		s_q.st != global_clock_led_pkg::ST_RUN |=> $stable(port_three_reduced_mii_negedge))
		else $error("Edge select changed before the bank was running.");

	// A write together with a read answers with the value from before the write.
	write_read_old_a: assert property (
		(s_q.st == global_clock_led_pkg::ST_RUN && req.wr && req.rd
			&& req.addr == global_clock_led_pkg::ADDR_RMII_EDGE_LED)
		|=> rsp.data[global_clock_led_pkg::BIT_P4_EDGE]
			== $past(port_four_reduced_mii_negedge))
		else $error("A write together with a read did not return the old value.");

	// The clock mode register shows the strapped status and its fixed reserved bit.
	status_read_a: assert property (
		(s_q.st == global_clock_led_pkg::ST_RUN && req.rd
			&& req.addr == global_clock_led_pkg::ADDR_CLOCK_MODE_SEL)
		|=> rsp.data[global_clock_led_pkg::BIT_CLK_MODE] == clock_mode_status
			&& rsp.data[global_clock_led_pkg::BIT_RSVD_ONE]
				== global_clock_led_pkg::RSVD_ONE_VAL)
		else $error("Clock mode register read a wrong status or fixed bit.");

	// LED patterns of each port, one cycle after the status they show.
	for (genvar p = 0; p < global_clock_led_pkg::NUM_LED_PORTS; p++) begin : g_led_chk
		led_mode_zero_a: assert property (
			!s_q.cfg.led_mode |=> port_led_second[p] == $past(port_status[p].link
				&& !port_status[p].activity)
				&& port_led_first[p] == $past(port_status[p].link && port_status[p].speed_100))
			else $error("LED mode 0 pattern is wrong.");
		led_mode_one_a: assert property (
			s_q.cfg.led_mode |=> port_led_second[p] == $past(port_status[p].link
				&& port_status[p].speed_100 && !port_status[p].activity)
				&& port_led_first[p] == $past(port_status[p].link
					&& port_status[p].full_duplex))
			else $error("LED mode 1 pattern is wrong.");
	end

	// Main scenarios worth seeing.
	normal_mode_c: cover property ($rose(s_q.st == global_clock_led_pkg::ST_RUN) && !clock_mode_status);
	led_mode_one_c: cover property (s_q.st == global_clock_led_pkg::ST_RUN && s_q.cfg.led_mode
		&& port_led_first != 2'h0);
	fast_clock_c: cover property (mgmt_clk_sel == global_clock_led_pkg::MGMT_CLK_125M
		&& read_sample_fast_edge);
	write_read_c: cover property (s_q.st == global_clock_led_pkg::ST_RUN && req.wr && req.rd);
	early_request_c: cover property (s_q.st != global_clock_led_pkg::ST_RUN && req.wr);

endmodule : global_clock_led_config

// >>> src/global_clock_led_pkg.sv
// Constants, register map and carrier types for the global clock and LED configuration bank.
package global_clock_led_pkg;

	// Register port widths.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// Register offsets.
	localparam logic [ADDR_W-1:0] ADDR_FACTORY_TEST_A = 8'h0a;
	localparam logic [ADDR_W-1:0] ADDR_RMII_EDGE_LED  = 8'h0b;
	localparam logic [ADDR_W-1:0] ADDR_CLOCK_MODE_SEL = 8'h0c;

	// Field positions in the edge and LED register.
	localparam int BIT_P3_EDGE    = 7;
	localparam int BIT_P4_EDGE    = 6;
	localparam int BIT_PHY_SAVE   = 3;
	localparam int BIT_LED_MODE   = 1;
	localparam int BIT_READ_EDGE  = 0;

	// Field positions in the clock mode register.
	localparam int BIT_CLK_MODE   = 6;
	localparam int CLK_SEL_LSB    = 4;
	localparam int BIT_RSVD_ONE   = 2;

	// Reset values and strap defaults.
	localparam logic [DATA_W-1:0] FACTORY_TEST_A_RST = 8'h00;
	localparam logic              LED_MODE_DEFAULT   = 1'h0;
	localparam logic              CLK_MODE_DEFAULT   = 1'h1;
	localparam logic              RSVD_ONE_VAL       = 1'h1;

	// Cycles after reset release before the synchronised straps are valid.
	localparam logic [1:0] STRAP_SETTLE = 2'h2;

	// Number of ports with LED outputs.
	localparam int NUM_LED_PORTS = 2;

	// Internal clock choices for the management interfaces, in field order.
	typedef enum logic [1:0] {
		MGMT_CLK_41M,
		MGMT_CLK_83M,
		MGMT_CLK_125M,
		MGMT_CLK_RSVD
	} mgmt_clk_t;

	localparam mgmt_clk_t MGMT_CLK_RST = MGMT_CLK_83M;

	// Strap capture sequence after reset.
	typedef enum logic [1:0] {
		ST_SETTLE,
		ST_CAPTURE,
		ST_RUN
	} strap_state_t;

	// Register access request and answer.
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic              valid;
		logic [DATA_W-1:0] data;
	} reg_rsp_t;

	// Per-port status that the LEDs display.
	typedef struct packed {
		logic link;
		logic activity;
		logic speed_100;
		logic full_duplex;
	} port_status_t;

	// Configuration held by the bank.
	typedef struct packed {
		logic      p3_negedge;
		logic      p4_negedge;
		logic      phy_power_save;
		logic      led_mode;
		logic      read_edge_fast;
		logic      clock_mode;
		mgmt_clk_t mgmt_clk;
	} cfg_t;

	// Whole state of the bank.
	typedef struct packed {
		strap_state_t             st;
		logic [1:0]               settle_cnt;
		logic [1:0]               led_sync;
		logic [1:0]               clk_sync;
		cfg_t                     cfg;
		reg_rsp_t                 rsp;
		logic [NUM_LED_PORTS-1:0] led_second;
		logic [NUM_LED_PORTS-1:0] led_first;
	} state_t;

endpackage : global_clock_led_pkg

// >>> tb/reg_host_model.sv
// Host processor model that issues register reads and writes on the request port.
`timescale 1ns/1ps
module reg_host_model (
	input  wire logic                           clk,
	output      global_clock_led_pkg::reg_req_t req,
	input  wire global_clock_led_pkg::reg_rsp_t rsp
);
	// The request port starts idle.
	initial begin
		req = '0;
	end

	// Holds a write for one taking edge, then scrambles the released fields.
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk);
		#1;
		req.addr  = addr;
		req.wdata = data;
		req.wr    = 1'b1;
		@(posedge clk);
		#1;
		req.wr    = 1'b0;
		req.addr  = ~addr;
		req.wdata = ~data;
	endtask : write_reg

	// Holds a read for one taking edge; the answer stands in the next cycle only.
	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
		@(posedge clk);
		#1;
		req.addr = addr;
		req.rd   = 1'b1;
		@(posedge clk);
		#1;
		req.rd   = 1'b0;
		req.addr = ~addr;
		data     = (rsp.valid === 1'b1) ? rsp.data : 8'hxx;
	endtask : read_reg

	// Write and read in one request; the answer carries the value from before the write.
	task automatic write_read_reg(input logic [7:0] addr, input logic [7:0] data,
		output logic [7:0] old);
		@(posedge clk);
		#1;
		req.addr  = addr;
		req.wdata = data;
		req.wr    = 1'b1;
		req.rd    = 1'b1;
		@(posedge clk);
		#1;
		req.wr    = 1'b0;
		req.rd    = 1'b0;
		req.addr  = ~addr;
		old       = (rsp.valid === 1'b1) ? rsp.data : 8'hxx;
	endtask : write_read_reg
endmodule : reg_host_model

// >>> tb/test_global_clock_led_config.sv
// Self-checking testbench for the global clock and LED configuration bank.
`timescale 1ns/1ps
module test_global_clock_led_config;
	logic                                       clk;
	logic                                       arst_n;
	global_clock_led_pkg::reg_req_t             req;
	global_clock_led_pkg::reg_rsp_t             rsp;
	logic                                       led_strap;
	logic                                       clk_strap;
	global_clock_led_pkg::port_status_t [1:0]   status;
	logic [1:0]                                 led_second;
	logic [1:0]                                 led_first;
	logic                                       p3_neg;
	logic                                       p4_neg;
	logic                                       power_save;
	logic                                       fast_edge;
	global_clock_led_pkg::mgmt_clk_t            mgmt_clk;
	logic                                       mode_status;
	logic                                       pll_xtal;
	logic                                       ref_oe;
	logic                                       core_ext;
	logic [7:0]                                 rdata;
	int                                         errors;
	int                                         check_count;

	global_clock_led_config u_dut (
		.clk                            (clk),
		.arst_n                         (arst_n),
		.req                            (req),
		.rsp                            (rsp),
		.led_mode_strap_pin             (led_strap),
		.clock_mode_strap_pin           (clk_strap),
		.port_status                    (status),
		.port_led_second                (led_second),
		.port_led_first                 (led_first),
		.port_three_reduced_mii_negedge (p3_neg),
		.port_four_reduced_mii_negedge  (p4_neg),
		.phy_power_save                 (power_save),
		.read_sample_fast_edge          (fast_edge),
		.mgmt_clk_sel                   (mgmt_clk),
		.clock_mode_status              (mode_status),
		.pll_source_crystal             (pll_xtal),
		.reference_clock_output_pin_oe  (ref_oe),
		.core_clock_external            (core_ext)
	);

	reg_host_model u_host (
		.clk (clk),
		.req (req),
		.rsp (rsp)
	);

	// Free-running 10 MHz clock.
	always #50 clk = ~clk;

	// Counts a comparison and reports a mismatch.
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t %s: saw %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	// Prints the verdict and ends the run.
	task automatic conclude();
		if (errors == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : conclude

	// Resets with the given strap levels and waits until requests are taken.
	task automatic apply_reset(input logic led_lvl, input logic clk_lvl);
		@(posedge clk);
		#1;
		arst_n    = 1'b0;
		led_strap = led_lvl;
		clk_strap = clk_lvl;
		repeat (20) @(posedge clk);
		#1;
		arst_n = 1'b1;
		repeat (5) @(posedge clk);
	endtask : apply_reset

	// Default straps: reset values of every register and the clock mode outputs.
	task automatic t_defaults();
		apply_reset(1'b0, 1'b1);
		u_host.read_reg(8'h0a, rdata);
		check(rdata, 8'h00, "factory test reset");
		u_host.read_reg(8'h0b, rdata);
		check(rdata, 8'h00, "edge and led reset");
		u_host.read_reg(8'h0c, rdata);
		check(rdata, 8'h54, "clock mode reset");
		u_host.read_reg(8'h20, rdata);
		check(rdata, 8'h00, "unmapped read");
		check({5'h0, pll_xtal, ref_oe, core_ext}, 8'h06, "crystal clock mode");
		check(8'(mgmt_clk), 8'h01, "mgmt clock reset");
	endtask : t_defaults

	// Edge selects take effect; reserved and factory bits stay at reset.
	task automatic t_edges();
		u_host.write_reg(8'h0b, 8'hff);
		check({4'h0, p3_neg, p4_neg, power_save, fast_edge}, 8'h0f, "edges set");
		u_host.read_reg(8'h0b, rdata);
		check(rdata, 8'hcb, "reserved bits kept");
		u_host.write_reg(8'h0a, 8'hff);
		u_host.read_reg(8'h0a, rdata);
		check(rdata, 8'h00, "factory test write");
		u_host.write_reg(8'h0b, 8'h00);
		check({4'h0, p3_neg, p4_neg, power_save, fast_edge}, 8'h00, "edges cleared");
	endtask : t_edges

	// Every legal clock select value, then the reserved value which is refused.
	task automatic t_clk_field();
		for (int v = 0; v < 3; v++) begin
			u_host.write_reg(8'h0c, 8'h8f | 8'(v << 4));
			check(8'(mgmt_clk), 8'(v), "mgmt clock select");
			u_host.read_reg(8'h0c, rdata);
			check(rdata, 8'h44 | 8'(v << 4), "clock reg readback");
		end
		u_host.write_reg(8'h0c, 8'h30);
		u_host.read_reg(8'h0c, rdata);
		check(rdata, 8'h64, "reserved select kept");
	endtask : t_clk_field

	// Opposite straps: external clock mode, LED mode 1, then software mode 0.
	task automatic t_straps();
		apply_reset(1'b1, 1'b0);
		u_host.read_reg(8'h0b, rdata);
		check(rdata, 8'h02, "led strap mode 1");
		u_host.read_reg(8'h0c, rdata);
		check(rdata, 8'h14, "normal mode strap");
		check({5'h0, pll_xtal, ref_oe, core_ext}, 8'h01, "external clock mode");
		u_host.write_reg(8'h0c, 8'h50);
		u_host.read_reg(8'h0c, rdata);
		check(rdata, 8'h14, "status bit read-only");
		check({6'h0, led_second}, 8'h01, "mode 1 second led");
		check({6'h0, led_first}, 8'h02, "mode 1 first led");
		u_host.write_reg(8'h0b, 8'h00);
		@(posedge clk);
		#1;
		check({6'h0, led_second}, 8'h03, "mode 0 second led");
		check({6'h0, led_first}, 8'h01, "mode 0 first led");
	endtask : t_straps

	// Write and read together: the write lands and the read returns the old value.
	task automatic t_order();
		u_host.write_read_reg(8'h0b, 8'h41, rdata);
		check(rdata, 8'h00, "old value beside write");
		check({4'h0, p3_neg, p4_neg, power_save, fast_edge}, 8'h05, "write with read");
		u_host.read_reg(8'h0b, rdata);
		check(rdata, 8'h41, "write with read landed");
	endtask : t_order

	// Activity blanks the second LED in both modes.
	task automatic t_activity();
		status = 8'hde;
		@(posedge clk);
		#1;
		check({6'h0, led_second}, 8'h00, "mode 0 activity second led");
		check({6'h0, led_first}, 8'h01, "mode 0 activity first led");
		u_host.write_reg(8'h0b, 8'h02);
		@(posedge clk);
		#1;
		check({6'h0, led_second}, 8'h00, "mode 1 activity second led");
		check({6'h0, led_first}, 8'h02, "mode 1 activity first led");
	endtask : t_activity

	// A write right after reset is dropped; the status keeps its reset value until capture.
	task automatic t_early();
		@(posedge clk);
		#1;
		arst_n    = 1'b0;
		led_strap = 1'b0;
		clk_strap = 1'b0;
		repeat (20) @(posedge clk);
		#1;
		arst_n = 1'b1;
		u_host.write_reg(8'h0b, 8'hc1);
		check({4'h0, p3_neg, p4_neg, fast_edge, mode_status}, 8'h01, "early write");
		repeat (3) @(posedge clk);
		u_host.read_reg(8'h0b, rdata);
		check(rdata, 8'h00, "early write left no trace");
		u_host.read_reg(8'h0c, rdata);
		check(rdata, 8'h14, "status after capture");
	endtask : t_early

	// Watchdog sized well above the expected run of about 135 cycles.
	initial begin
		#2000000;
		errors++;
		conclude();
	end

	// Main sequence.
	initial begin
		clk         = 1'b0;
		arst_n      = 1'b0;
		led_strap   = 1'b0;
		clk_strap   = 1'b1;
		status      = 8'h9a;
		errors      = 0;
		check_count = 0;
		t_defaults();
		t_edges();
		t_clk_field();
		t_straps();
		t_order();
		t_activity();
		t_early();
		conclude();
	end
endmodule : test_global_clock_led_config
